// *** tccap_pkg.sv ***
// Constants, field layout and types of the three-channel capture timer
// Operation
// - Route line 0: pin0, none, chan1 A, chan2 A
// - Route line 1: pin1, none, chan0 A, chan2 A
// - Route line 2: pin2, none, chan0 A, chan1 A
// - Clock-on command enables unless clock-off also set
// - Clock-off command disables the counter clock
// - Software trigger resets counter and restarts a stopped clock
// - Source: master clock /2../1024, or lines 0-2
// - Invert bit selects falling instead of rising edge
// - Gating field ANDs clock with external line
// - Second capture load stops clock when enabled
// - Second capture load disables clock when enabled
// - Trigger edge: none, rising, falling, both
// - Trigger line: line B at zero, A at one
// - Compare C match restarts counter when enabled
// - Mode bit: capture at zero, waveform at one
// - First capture loads on selected line A edge
// - Second capture loads on selected line A edge
// - Sync command triggers all three channels together
// - Status flags set on event, cleared on read
`default_nettype none
package tccap_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W  = 16;
   localparam int N_CHAN = 3;
   localparam int DIV_W  = 10;
   localparam int STAT_W = 8;
   // ****************************************
   // Register offsets within a channel and block
   // ****************************************
   localparam logic [5:0] OFF_CMD   = 6'h00;
   localparam logic [5:0] OFF_CFG   = 6'h04;
   localparam logic [5:0] OFF_CV    = 6'h10;
   localparam logic [5:0] OFF_CAP_A = 6'h14;
   localparam logic [5:0] OFF_CAP_B = 6'h18;
   localparam logic [5:0] OFF_CMP_C = 6'h1c;
   localparam logic [5:0] OFF_STAT  = 6'h20;
   localparam logic [7:0] OFF_SYNC  = 8'hc0;
   localparam logic [7:0] OFF_ROUTE = 8'hc4;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int CMD_CLK_ON  = 0;
   localparam int CMD_CLK_OFF = 1;
   localparam int CMD_TRIG    = 2;
   localparam int SYNC_BIT    = 0;
   localparam int CFG_SRC     = 0;
   localparam int CFG_INV     = 3;
   localparam int CFG_GATE    = 4;
   localparam int CFG_STOPB   = 6;
   localparam int CFG_DISB    = 7;
   localparam int CFG_ETRG    = 8;
   localparam int CFG_TRGSEL  = 10;
   localparam int CFG_CRST    = 14;
   localparam int CFG_WAVE    = 15;
   localparam int CFG_LDA     = 16;
   localparam int CFG_LDB     = 18;
   localparam logic [31:0] CFG_MASK    = 32'h000fc7ff;
   localparam logic [31:0] ROUTE_MASK  = 32'h0000003f;
   localparam logic [31:0] CFG_RESET   = 32'h00000000;
   localparam logic [31:0] ROUTE_RESET = 32'h00000000;
   localparam int ST_OVF   = 0;
   localparam int ST_OVR   = 1;
   localparam int ST_CMPC  = 4;
   localparam int ST_LDA   = 5;
   localparam int ST_LDB   = 6;
   localparam int ST_ETRG  = 7;
   localparam int ST_CLKON = 16;
   // Divider taps giving master clock /2, /8, /32, /128, /1024
   localparam int TAP2 = 0;
   localparam int TAP8 = 2;
   localparam int TAP32 = 4;
   localparam int TAP128 = 6;
   localparam int TAP1024 = 9;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
   typedef enum logic [1:0] {
      EDGE_NONE = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_FALL = 2'b10,
      EDGE_BOTH = 2'b11
   } tccap_edge_t;
endpackage
`default_nettype wire

// *** tccap_edge_if.sv ***
// Carrier between an edge detector and its user
`timescale 1ns/1ns
`default_nettype none
interface tccap_edge_if;
   import tccap_pkg::*;
   logic        level;
   tccap_edge_t mode;
   logic        hit;
   modport det  (input level, input mode, output hit);
   modport user (output level, output mode, input hit);
endinterface
`default_nettype wire

// *** tccap_edge.sv ***
// Selectable edge detector on a synchronous level
`timescale 1ns/1ns
`default_nettype none
module tccap_edge (
   // Clock and reset
   input wire logic    clk,
   input wire logic    resetn,
   // Level in, pulse out
   tccap_edge_if.det   e
);
   import tccap_pkg::*;
   logic prev_reg;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= e.level;
      end
   end
   // Pulse in the cycle the new level is seen
   always_comb begin
      unique case (e.mode)
         EDGE_NONE: e.hit = 1'b0;
         EDGE_RISE: e.hit = e.level & ~prev_reg;
         EDGE_FALL: e.hit = ~e.level & prev_reg;
         EDGE_BOTH: e.hit = e.level ^ prev_reg;
      endcase
   end
endmodule
`default_nettype wire

// *** tccap_prescale.sv ***
// Free-running master clock divider with fixed taps
`timescale 1ns/1ns
`default_nettype none
module tccap_prescale (
   // Clock and reset
   input wire logic        clk,
   input wire logic        resetn,
   // Divided levels, lowest ratio first
   output logic [4:0]      tap
);
   import tccap_pkg::*;
   logic [DIV_W-1:0] div_reg;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 10'h001;
      end
   end
   // Bit n toggles every 2^n cycles, so its period is 2^(n+1) cycles
   assign tap = {div_reg[TAP1024], div_reg[TAP128], div_reg[TAP32],
                 div_reg[TAP8], div_reg[TAP2]};
endmodule
`default_nettype wire

// *** tccap_top.sv ***
// Three-channel 16-bit capture timer with register port
`timescale 1ns/1ns
`default_nettype none
module tccap_top (
   // Clock and reset
   input wire logic                         clk,
   input wire logic                         resetn,
   // Register port
   input wire logic [tccap_pkg::ADDR_W-1:0] addr,
   input wire logic [tccap_pkg::DATA_W-1:0] wr_data,
   input wire logic                         wr_en,
   input wire logic                         rd_en,
   output logic [tccap_pkg::DATA_W-1:0]     rd_data,
   // Channel pins
   input wire logic [2:0]                   clock_input_pin,
   input wire logic [2:0]                   channel_io_a,
   input wire logic [2:0]                   channel_io_b,
   // Clock state per channel
   output logic [2:0]                       chan_clock_on
);
   import tccap_pkg::*;

   // ****************************************
   // Block registers and decode
   // ****************************************
   logic [5:0]        route_reg;
   logic [DATA_W-1:0] rd_data_reg;
   logic [2:0]        ext_clock_line;
   logic [4:0]        div_tap;
   logic              sync_wr;
   logic              route_wr;
   logic [DATA_W-1:0] rd_next;

   assign sync_wr  = wr_en && (addr == OFF_SYNC) && wr_data[SYNC_BIT];
   assign route_wr = wr_en && (addr == OFF_ROUTE);
   assign rd_data  = rd_data_reg;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         route_reg <= ROUTE_RESET[5:0];
      end else if (route_wr) begin
         route_reg <= wr_data[5:0] & ROUTE_MASK[5:0];
      end
   end

   // ****************************************
   // External clock line routing
   // ****************************************
   always_comb begin
      unique case (route_reg[1:0])
         2'b00: ext_clock_line[0] = clock_input_pin[0];
         2'b01: ext_clock_line[0] = 1'b0;
         2'b10: ext_clock_line[0] = channel_io_a[1];
         2'b11: ext_clock_line[0] = channel_io_a[2];
      endcase
      unique case (route_reg[3:2])
         2'b00: ext_clock_line[1] = clock_input_pin[1];
         2'b01: ext_clock_line[1] = 1'b0;
         2'b10: ext_clock_line[1] = channel_io_a[0];
         2'b11: ext_clock_line[1] = channel_io_a[2];
      endcase
      unique case (route_reg[5:4])
         2'b00: ext_clock_line[2] = clock_input_pin[2];
         2'b01: ext_clock_line[2] = 1'b0;
         2'b10: ext_clock_line[2] = channel_io_a[0];
         2'b11: ext_clock_line[2] = channel_io_a[1];
      endcase
   end

   tccap_prescale u_prescale (
      .clk    (clk),
      .resetn (resetn),
      .tap    (div_tap)
   );

   // ****************************************
   // Per-channel state
   // ****************************************
   logic [DATA_W-1:0] cfg_reg  [N_CHAN];
   logic [CNT_W-1:0]  cv_reg   [N_CHAN];
   logic [CNT_W-1:0]  cap_a_reg [N_CHAN];
   logic [CNT_W-1:0]  cap_b_reg [N_CHAN];
   logic [CNT_W-1:0]  cmp_c_reg [N_CHAN];
   logic [STAT_W-1:0] stat_reg [N_CHAN];
   logic              en_reg   [N_CHAN];
   logic              stop_reg [N_CHAN];

   genvar i;
   generate
      for (i = 0; i < N_CHAN; i++) begin : g_chan
         logic [DATA_W-1:0] cfg;
         logic              sel_wr;
         logic              cmd_wr;
         logic              stat_rd;
         logic              sel_lvl;
         logic              gate_lvl;
         logic              tick;
         logic              sw_trig;
         logic              cmp_hit;
         logic              restart;
         logic              trig;
         logic              cap_on;
         logic              lda_ev;
         logic              ldb_ev;
         logic              ovf;
         logic [STAT_W-1:0] stat_set;

         tccap_edge_if cnt_if ();
         tccap_edge_if trg_if ();
         tccap_edge_if lda_if ();
         tccap_edge_if ldb_if ();

         assign cfg     = cfg_reg[i];
         assign sel_wr  = wr_en && (addr[7:6] == 2'(i));
         assign cmd_wr  = sel_wr && (addr[5:0] == OFF_CMD);
         assign stat_rd = rd_en && (addr[7:6] == 2'(i)) && (addr[5:0] == OFF_STAT);

         // Counting clock: source, then gate, then edge polarity
         always_comb begin
            unique case (cfg[CFG_SRC +: 3])
               3'b000: sel_lvl = div_tap[0];
               3'b001: sel_lvl = div_tap[1];
               3'b010: sel_lvl = div_tap[2];
               3'b011: sel_lvl = div_tap[3];
               3'b100: sel_lvl = div_tap[4];
               3'b101: sel_lvl = ext_clock_line[0];
               3'b110: sel_lvl = ext_clock_line[1];
               3'b111: sel_lvl = ext_clock_line[2];
            endcase
            unique case (cfg[CFG_GATE +: 2])
               2'b00: gate_lvl = 1'b1;
               2'b01: gate_lvl = ext_clock_line[0];
               2'b10: gate_lvl = ext_clock_line[1];
               2'b11: gate_lvl = ext_clock_line[2];
            endcase
         end

         assign cnt_if.level = sel_lvl & gate_lvl;
         assign cnt_if.mode  = cfg[CFG_INV] ? EDGE_FALL : EDGE_RISE;
         assign trg_if.level = cfg[CFG_TRGSEL] ? channel_io_a[i] : channel_io_b[i];
         assign trg_if.mode  = tccap_edge_t'(cfg[CFG_ETRG +: 2]);
         assign lda_if.level = channel_io_a[i];
         assign lda_if.mode  = tccap_edge_t'(cfg[CFG_LDA +: 2]);
         assign ldb_if.level = channel_io_a[i];
         assign ldb_if.mode  = tccap_edge_t'(cfg[CFG_LDB +: 2]);

         tccap_edge u_cnt (.clk(clk), .resetn(resetn), .e(cnt_if.det));
         tccap_edge u_trg (.clk(clk), .resetn(resetn), .e(trg_if.det));
         tccap_edge u_lda (.clk(clk), .resetn(resetn), .e(lda_if.det));
         tccap_edge u_ldb (.clk(clk), .resetn(resetn), .e(ldb_if.det));

         // Waveform mode has no output logic here, so captures are held off
         assign cap_on  = ~cfg[CFG_WAVE];
         assign lda_ev  = cap_on & lda_if.hit;
         assign ldb_ev  = cap_on & ldb_if.hit;
         assign tick    = cnt_if.hit & en_reg[i] & ~stop_reg[i];
         assign cmp_hit = tick && (cv_reg[i] == cmp_c_reg[i]);
         assign restart = cmp_hit & cfg[CFG_CRST];
         assign sw_trig = (cmd_wr & wr_data[CMD_TRIG]) | sync_wr;
         assign trig    = sw_trig | trg_if.hit | restart;
         assign ovf     = tick && (cv_reg[i] == CNT_MAX) && !trig;

         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               cfg_reg[i] <= CFG_RESET;
            end else if (sel_wr && (addr[5:0] == OFF_CFG)) begin
               cfg_reg[i] <= wr_data & CFG_MASK;
            end
         end

         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               cmp_c_reg[i] <= '0;
            end else if (sel_wr && (addr[5:0] == OFF_CMP_C)) begin
               cmp_c_reg[i] <= wr_data[CNT_W-1:0];
            end
         end

         // Clock enable: off beats on in one write, a load can also disable
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               en_reg[i] <= 1'b0;
            end else if (cmd_wr && wr_data[CMD_CLK_OFF]) begin
               en_reg[i] <= 1'b0;
            end else if (cmd_wr && wr_data[CMD_CLK_ON]) begin
               en_reg[i] <= 1'b1;
            end else if (ldb_ev && cfg[CFG_DISB]) begin
               en_reg[i] <= 1'b0;
            end
         end

         // A trigger restarts a stopped clock; it cannot undo a disable
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               stop_reg[i] <= 1'b0;
            end else if (trig) begin
               stop_reg[i] <= 1'b0;
            end else if (ldb_ev && cfg[CFG_STOPB]) begin
               stop_reg[i] <= 1'b1;
            end
         end

         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               cv_reg[i] <= '0;
            end else if (trig) begin
               cv_reg[i] <= '0;
            end else if (tick) begin
               cv_reg[i] <= cv_reg[i] + 16'h0001;
            end
         end

         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               cap_a_reg[i] <= '0;
            end else if (lda_ev) begin
               cap_a_reg[i] <= cv_reg[i];
            end
         end

         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               cap_b_reg[i] <= '0;
            end else if (ldb_ev) begin
               cap_b_reg[i] <= cv_reg[i];
            end
         end

         // Sticky events; a new event in the reading cycle survives the clear
         always_comb begin
            stat_set          = '0;
            stat_set[ST_OVF]  = ovf;
            stat_set[ST_OVR]  = (lda_ev & stat_reg[i][ST_LDA]) |
                                (ldb_ev & stat_reg[i][ST_LDB]);
            stat_set[ST_CMPC] = cmp_hit;
            stat_set[ST_LDA]  = lda_ev;
            stat_set[ST_LDB]  = ldb_ev;
            stat_set[ST_ETRG] = trg_if.hit;
         end

         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               stat_reg[i] <= '0;
            end else if (stat_rd) begin
               stat_reg[i] <= stat_set;
            end else begin
               stat_reg[i] <= stat_reg[i] | stat_set;
            end
         end

         assign chan_clock_on[i] = en_reg[i];
      end
   endgenerate

   // ****************************************
   // Read data, valid only in the cycle after the strobe
   // ****************************************
   always_comb begin
      int unsigned c;
      c = 32'(addr[7:6]);
      rd_next = '0;
      if (addr == OFF_ROUTE) begin
         rd_next = {26'h0, route_reg};
      end else if (c < N_CHAN) begin
         unique case (addr[5:0])
            OFF_CFG:  rd_next = cfg_reg[c];
            OFF_CV:   rd_next = {16'h0, cv_reg[c]};
            OFF_CAP_A: rd_next = {16'h0, cap_a_reg[c]};
            OFF_CAP_B: rd_next = {16'h0, cap_b_reg[c]};
            OFF_CMP_C: rd_next = {16'h0, cmp_c_reg[c]};
            OFF_STAT: begin
               rd_next = {24'h0, stat_reg[c]};
               rd_next[ST_CLKON] = en_reg[c];
            end
            default:  rd_next = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_data_reg <= '0;
      end else if (rd_en) begin
         rd_data_reg <= rd_next;
      end else begin
         rd_data_reg <= '0;
      end
   end
endmodule
`default_nettype wire

// *** tccap_sva.sv ***
// Port-level checker for the capture timer
`timescale 1ns/1ns
`default_nettype none
module tccap_sva (
   // Clock and reset
   input wire logic                         clk,
   input wire logic                         resetn,
   // Register port
   input wire logic [tccap_pkg::ADDR_W-1:0] addr,
   input wire logic [tccap_pkg::DATA_W-1:0] wr_data,
   input wire logic                         wr_en,
   input wire logic                         rd_en,
   input wire logic [tccap_pkg::DATA_W-1:0] rd_data,
   // Clock state
   input wire logic [2:0]                   chan_clock_on
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // ****
   // Command effects
   // ****
   chk_off_cmd: assert property (
      wr_en && addr == 8'h00 && wr_data[1] |=> !chan_clock_on[0])
      else $error("clock on after off command");
   chk_off_wins: assert property (
      wr_en && addr == 8'h40 && wr_data[1:0] == 2'b11 |=> !chan_clock_on[1])
      else $error("on command beat off command");
   chk_on_trig: assert property (
      wr_en && addr == 8'h80 && wr_data[2:0] == 3'b101 |=> chan_clock_on[2])
      else $error("clock not started");
   chk_trig_off: assert property (
      wr_en && addr == 8'h00 && wr_data[2:1] == 2'b11 |=> !chan_clock_on[0])
      else $error("trigger revived a disabled clock");
   // ****
   // Register reads
   // ****
   chk_route_rb: assert property (
      wr_en && addr == 8'hc4 ##1 rd_en && addr == 8'hc4
      |=> rd_data == ($past(wr_data, 2) & 32'h0000003f))
      else $error("routing readback wrong");
   chk_cfg_rb: assert property (
      wr_en && addr == 8'h04 ##1 rd_en && addr == 8'h04
      |=> rd_data == ($past(wr_data, 2) & 32'h000fc7ff))
      else $error("config readback wrong");
   chk_cmd_wo: assert property (
      rd_en && (addr == 8'h00 || addr == 8'hc0) |=> rd_data == 32'h00000000)
      else $error("write-only place read nonzero");
   chk_rd_quiet: assert property (!rd_en |=> rd_data == 32'h00000000)
      else $error("read data outside read slot");
   cov_sync: cover property (wr_en && addr == 8'hc0 && wr_data[0]);
   cov_stop: cover property (chan_clock_on[0] ##1 !chan_clock_on[0]);
   cov_stat: cover property (rd_en && addr == 8'h20);
endmodule
bind tccap_top tccap_sva u_tccap_sva (.clk(clk), .resetn(resetn), .addr(addr),
   .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
   .chan_clock_on(chan_clock_on));
`default_nettype wire

// *** tccap_pins.sv ***
// Far-side model: clock bursts and channel lines
`timescale 1ns/1ns
`default_nettype none
module tccap_pins (
   // Clock and reset
   input wire logic        clk,
   input wire logic        resetn,
   // Requests from the bench
   input wire logic [2:0]  run_clk,
   input wire logic [2:0]  run_a,
   input wire logic [2:0]  lvl_b,
   // Pins
   output logic [2:0]      clock_input_pin,
   output logic [2:0]      channel_io_a,
   output logic [2:0]      channel_io_b
);
   // Bursts toggle each cycle and rest low, so no stray edge appears between them
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         clock_input_pin <= 3'h0;
         channel_io_a    <= 3'h0;
         channel_io_b    <= 3'h0;
      end else begin
         clock_input_pin <= run_clk & ~clock_input_pin;
         channel_io_a    <= run_a & ~channel_io_a;
         channel_io_b    <= lvl_b;
      end
   end
endmodule
`default_nettype wire

// *** tccap_tb.sv ***
// Self-checking bench for the capture timer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import tccap_pkg::*;
   logic              clk = 1'b0;
   logic              resetn = 1'b0;
   logic [ADDR_W-1:0] addr = 8'h00;
   logic [DATA_W-1:0] wr_data = 32'h0;
   logic              wr_en = 1'b0;
   logic              rd_en = 1'b0;
   logic [DATA_W-1:0] rd_data;
   logic [2:0]        pin, io_a, io_b, clk_on;
   logic [2:0]        run_clk = 3'h0;
   logic [2:0]        run_a = 3'h0;
   logic [2:0]        lvl_b = 3'h0;
   logic [31:0]       seed = 32'hc3235b61;
   logic [7:0]        rst_addr [7] = '{8'h04, 8'h44, 8'h84, 8'hc4, 8'h00, 8'h08, 8'hc0};
   logic [2:0]        cmd_seq [8] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7, 3'h4};
   logic [0:7]        cmd_exp = 8'b11001000;
   int                err_count = 0;
   int                compares = 0;
   always #5 clk = ~clk;
   tccap_top u_tccap_top (.clk(clk), .resetn(resetn), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .clock_input_pin(pin),
      .channel_io_a(io_a), .channel_io_b(io_b), .chan_clock_on(clk_on));
   tccap_pins u_tccap_pins (.clk(clk), .resetn(resetn), .run_clk(run_clk), .run_a(run_a),
      .lvl_b(lvl_b), .clock_input_pin(pin), .channel_io_a(io_a), .channel_io_b(io_b));
   // ****
   // Bus tasks, entered just after a rising edge
   // ****
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic idle(input int n);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      repeat (n) @(posedge clk);
   endtask
   // Strobe stays up so a following access can run with no gap
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      rd_en <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      addr <= a;
      rd_en <= 1'b1;
      wr_en <= 1'b0;
      @(posedge clk);
      idle(1);
      v = rd_data;
   endtask
   task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_bits(input string n, input logic [2:0] e, input logic [2:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic tally_and_finish;
      $display("compares %0d, err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      tally_and_finish();
   end
   // ****
   // Main sequence
   // ****
   initial begin : main
      logic [31:0] v, d, mk;
      logic [7:0]  a;
      int          m;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 7; i++) begin
         rd(rst_addr[i], v);
         chk_word("reset read", 32'h0, v);
      end
      for (int i = 0; i < 12; i++) begin
         d = (i < 4) ? 32'hffffffff : xs();
         a = (i % 4 == 3) ? 8'hc4 : 8'(4 + 64 * (i % 4));
         mk = (i % 4 == 3) ? ROUTE_MASK : CFG_MASK;
         wr(a, d);
         rd(a, v);
         chk_word("readback", d & mk, v);
         wr(a, 32'h0);
      end
      for (int c = 0; c < 3; c++) begin
         foreach (cmd_seq[j]) begin
            wr(8'(64 * c), {29'h0, cmd_seq[j]});
            idle(1);
            chk_bits("clock state", {2'b0, cmd_exp[j]} << c, clk_on);
         end
      end
      rd(8'h10, v);
      chk_word("count after trigger", 32'h0, v);
      // Pass 4 counts falling edges and pass 5 gates the master clock by a quiet line
      for (int r = 0; r < 6; r++) begin
         m = 2 + int'(xs() % 32'h6);
         wr(8'h04, (r == 4) ? 32'h0000000d : (r == 5) ? 32'h00000010 : 32'h00000005);
         wr(8'hc4, (r < 4) ? 32'(r) : 32'h0);
         wr(8'h00, 32'h5);
         run_clk <= (r < 2 || r == 4) ? 3'b001 : 3'b000;
         run_a <= (r == 2) ? 3'b010 : (r == 3) ? 3'b100 : 3'b000;
         idle(2 * m);
         run_clk <= 3'b000;
         run_a <= 3'b000;
         idle(4);
         rd(8'h10, v);
         chk_word("line count", (r % 4 == 1) ? 32'h0 : 32'(m), v);
      end
      wr(8'hc4, 32'h0);
      wr(8'h04, 32'h00090045);
      wr(8'h00, 32'h5);
      run_clk <= 3'b001;
      idle(10);
      run_clk <= 3'b000;
      idle(4);
      run_a <= 3'b001;
      idle(2);
      run_a <= 3'b000;
      idle(4);
      rd(8'h14, v);
      chk_word("capture a", 32'h5, v);
      rd(8'h18, v);
      chk_word("capture b", 32'h5, v);
      chk_bits("clock kept on", 3'b001, clk_on);
      run_clk <= 3'b001;
      idle(6);
      run_clk <= 3'b000;
      idle(2);
      rd(8'h10, v);
      chk_word("stop on load", 32'h5, v);
      rd(8'h20, v);
      chk_word("status set", 32'h60, v & 32'h60);
      rd(8'h20, v);
      chk_word("status cleared", 32'h0, v & 32'h60);
      wr(8'hc0, 32'h1);
      idle(1);
      chk_bits("sync restart", 3'b001, clk_on);
      rd(8'h10, v);
      chk_word("sync count", 32'h0, v);
      wr(8'h9c, 32'h5);
      for (int k = 0; k < 2; k++) begin
         wr(8'h84, k ? 32'h4000 : 32'h0);
         wr(8'h80, 32'h5);
         idle(40);
         rd(8'h90, v);
         chk_word("compare restart", 32'(k), {31'h0, v <= 32'h5});
      end
      // Pass 4 selects line A, which stays quiet while line B moves
      for (int e = 0; e < 5; e++) begin
         wr(8'h44, (e == 4) ? 32'h00000700 : 32'(e) << 8);
         wr(8'h40, 32'h5);
         idle(30);
         lvl_b <= 3'b010;
         idle(3);
         rd(8'h50, v);
         chk_word("ext rise", 32'(e == 1 || e == 3), {31'h0, v < 32'h8});
         idle(30);
         lvl_b <= 3'b000;
         idle(3);
         rd(8'h50, v);
         chk_word("ext fall", 32'(e == 2 || e == 3), {31'h0, v < 32'h8});
      end
      idle(2);
      tally_and_finish();
   end
endmodule
`default_nettype wire
